// [mcah_consts.vh]
// Purpose: Constants of the MODBUS control action handler.
// Assumes: Parsed MODBUS requests arrive from a frame layer on i_clk.
// Notes:   Register numbers are MODBUS register addresses, not bytes.
`ifndef MCAH_CONSTS_VH
`define MCAH_CONSTS_VH

// Function and exception codes
`define MCAH_FN_READ     8'h04
`define MCAH_FN_WRITE    8'h10
`define MCAH_FN_EXC_BIT  8'h80
`define MCAH_EXC_FUNC    8'h01
`define MCAH_EXC_ADDR    8'h02
`define MCAH_EXC_DATA    8'h03
`define MCAH_EXC_NONE    8'h00

// Register map
`define MCAH_ADDR_PT_CMD 16'h6000
`define MCAH_ADDR_PT_RPL 16'h6100
`define MCAH_ADDR_CTL    16'h6200
`define MCAH_ADDR_CTL_LS 16'h6203
`define MCAH_CTL_QTY     16'h0003
`define MCAH_CTL_BYTES   8'h06
`define MCAH_MAX_RD_QTY  16'h007D

// Slices of the six captured control bytes
`define MCAH_SL_B1       47:40
`define MCAH_SL_B0       39:32
`define MCAH_SL_C2       31:24
`define MCAH_SL_B2       23:16
`define MCAH_SL_C0       15:8
`define MCAH_SL_C1       7:0

// Action group selectors
`define MCAH_B_ZERO      8'h00
`define MCAH_B_ONE       8'h01
`define MCAH_B_TWO       8'h02
`define MCAH_G_STAT      8'h03
`define MCAH_G_RELAY     8'h04
`define MCAH_G_DI        8'h06

// Action codes in byte 0
`define MCAH_C_PEAK_W    8'h04
`define MCAH_C_ENERGY    8'h08
`define MCAH_C_DSYNC     8'h40
`define MCAH_C_SNAP      8'h80
`define MCAH_C_PEAK_I    8'h01
`define MCAH_C_ALL_MM    8'h04
`define MCAH_C_INCNT     8'h06
`define MCAH_C_MM_FIRST  8'h0D
`define MCAH_C_MM_LAST   8'h12
`define MCAH_C_FB_STAT   8'h02
`define MCAH_C_PR_STAT   8'h03
`define MCAH_C_ACK_E     8'h06
`define MCAH_C_DI_ACK    8'h00

// One-hot action outputs
`define MCAH_ACT_W       17
`define MCAH_A_PEAK_W    0
`define MCAH_A_ENERGY    1
`define MCAH_A_DSYNC     2
`define MCAH_A_SNAP      3
`define MCAH_A_PEAK_I    4
`define MCAH_A_ALL_MM    5
`define MCAH_A_INCNT     6
`define MCAH_A_MM_BASE   7
`define MCAH_A_FB_STAT   13
`define MCAH_A_PR_STAT   14
`define MCAH_A_ACK_E     15
`define MCAH_A_DI_ACK    16

// Reply message status byte
`define MCAH_STAT_OK     8'h00
`define MCAH_STAT_BAD    8'hFF

`endif

// [mcah_reply_store.v]
// Purpose: Holding store for pass-through reply messages.
// Assumes: One writer and one reader, both on i_clk.
// Notes:   Read is combinational so the streamer needs no extra cycle.
`timescale 1ns/10ps
module mcah_reply_store #(
  parameter P_AW = 4,
  parameter P_DW = 32
) (
  // Clock
  input  wire            i_clk,
  // Write side
  input  wire            i_wr_en,
  input  wire [P_AW-1:0] i_wr_addr,
  input  wire [P_DW-1:0] i_wr_data,
  // Read side
  input  wire [P_AW-1:0] i_rd_addr,
  output wire [P_DW-1:0] o_rd_data
);

  reg [P_DW-1:0] mem [0:(1<<P_AW)-1];

  // Words are stored untouched
  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  assign o_rd_data = mem[i_rd_addr];

endmodule

// [mcah_handler.v]
// Purpose: Control action and pass-through handler behind a MODBUS slave.
// Assumes: Frame layer delivers parsed requests and data bytes on i_clk;
//          lock level and field-bus transceiver are on i_clk too.
// Notes:   One request at a time; reads stream one byte per cycle.
`timescale 1ns/10ps
`include "mcah_consts.vh"
module mcah_handler #(
  parameter P_MSG_AW    = 4,
  parameter P_CHECK_CPL = 0
) (
  // Clock and reset
  input  wire                  i_clk,
  input  wire                  i_rst,
  // Parsed request
  input  wire                  i_req_valid,
  input  wire [7:0]            i_req_func,
  input  wire [15:0]           i_req_addr,
  input  wire [15:0]           i_req_qty,
  input  wire [7:0]            i_req_bytes,
  output reg                   o_req_ready,
  // Request write data
  input  wire                  i_wr_valid,
  input  wire [7:0]            i_wr_byte,
  output reg                   o_wr_ready,
  // Response header
  output reg                   o_rsp_valid,
  output reg  [7:0]            o_rsp_func,
  output reg  [15:0]           o_rsp_addr,
  output reg  [15:0]           o_rsp_qty,
  output reg  [7:0]            o_rsp_bytes,
  output reg  [7:0]            o_rsp_exc_code,
  // Read data
  output reg                   o_rd_valid,
  output reg  [7:0]            o_rd_byte,
  output reg                   o_rd_last,
  // Lock and actions
  input  wire                  i_system_lock_state,
  output reg  [`MCAH_ACT_W-1:0] o_action,
  output reg  [1:0]            o_relay,
  // Field-bus product
  output reg                   o_fb_cmd_valid,
  output reg  [7:0]            o_fb_cmd_byte,
  output reg                   o_fb_cmd_last,
  input  wire                  i_fb_cmd_ready,
  input  wire                  i_fb_rsp_valid,
  input  wire [23:0]           i_fb_rsp_data,
  input  wire                  i_fb_rsp_ok,
  // Held reply status
  output reg  [P_MSG_AW:0]     o_reply_message_count
);

  localparam S_IDLE  = 3'd0;
  localparam S_CTL   = 3'd1;
  localparam S_EXEC  = 3'd2;
  localparam S_PT    = 3'd3;
  localparam S_DRAIN = 3'd4;
  localparam S_RSP   = 3'd5;
  localparam S_RD    = 3'd6;

  localparam [P_MSG_AW:0] DEPTH = {1'b1, {P_MSG_AW{1'b0}}};

  // Maps the three action bytes to a one-hot action, zero if unknown
  function [`MCAH_ACT_W-1:0] mcah_decode;
    input [7:0] b2;
    input [7:0] b1;
    input [7:0] b0;
    reg   [`MCAH_ACT_W-1:0] a;
    begin
      a = {`MCAH_ACT_W{1'b0}};
      if (b2 == `MCAH_B_ZERO && b1 == `MCAH_B_ZERO) begin
        case (b0)
          `MCAH_C_PEAK_W: a[`MCAH_A_PEAK_W] = 1'b1;
          `MCAH_C_ENERGY: a[`MCAH_A_ENERGY] = 1'b1;
          `MCAH_C_DSYNC:  a[`MCAH_A_DSYNC]  = 1'b1;
          `MCAH_C_SNAP:   a[`MCAH_A_SNAP]   = 1'b1;
          default:        a = {`MCAH_ACT_W{1'b0}};
        endcase
      end else if (b2 == `MCAH_B_ZERO && b1 == `MCAH_B_ONE) begin
        case (b0)
          `MCAH_C_PEAK_I: a[`MCAH_A_PEAK_I] = 1'b1;
          `MCAH_C_ALL_MM: a[`MCAH_A_ALL_MM] = 1'b1;
          `MCAH_C_INCNT:  a[`MCAH_A_INCNT]  = 1'b1;
          default: begin
            if (b0 >= `MCAH_C_MM_FIRST && b0 <= `MCAH_C_MM_LAST) begin
              a[`MCAH_A_MM_BASE + b0 - `MCAH_C_MM_FIRST] = 1'b1;
            end
          end
        endcase
      end else if (b2 == `MCAH_G_STAT && b1 == `MCAH_B_ZERO) begin
        case (b0)
          `MCAH_C_FB_STAT: a[`MCAH_A_FB_STAT] = 1'b1;
          `MCAH_C_PR_STAT: a[`MCAH_A_PR_STAT] = 1'b1;
          `MCAH_C_ACK_E:   a[`MCAH_A_ACK_E]   = 1'b1;
          default:         a = {`MCAH_ACT_W{1'b0}};
        endcase
      end else if (b2 == `MCAH_G_DI && b1 == `MCAH_G_DI &&
                   b0 == `MCAH_C_DI_ACK) begin
        a[`MCAH_A_DI_ACK] = 1'b1;
      end
      mcah_decode = a;
    end
  endfunction

  // Picks byte lane 0..3 of a word, most significant first
  function [7:0] mcah_lane;
    input [31:0] w;
    input [1:0]  lane;
    begin
      case (lane)
        2'd0:    mcah_lane = w[31:24];
        2'd1:    mcah_lane = w[23:16];
        2'd2:    mcah_lane = w[15:8];
        default: mcah_lane = w[7:0];
      endcase
    end
  endfunction

  reg  [2:0]   state;
  reg  [7:0]   func;
  reg  [15:0]  addr;
  reg  [15:0]  qty;
  reg  [7:0]   nbytes;
  reg  [7:0]   cnt;
  reg  [47:0]  ctl_sh;
  reg          rd_req;
  wire [31:0]  rd_word;
  wire [16:0]  ctl_end;
  wire         ctl_touch;
  wire         ctl_exact;
  wire         pt_ok;
  wire         rd_ok;
  wire         cpl_ok;
  wire [8:0]   qty_bytes;
  wire [7:0]   b0;
  wire [7:0]   b1;
  wire [7:0]   b2;
  wire         in_range;

  // Request classification, done in the cycle the request is taken
  assign ctl_end   = {1'b0, i_req_addr} + {1'b0, i_req_qty};
  assign ctl_touch = (i_req_addr <= `MCAH_ADDR_CTL_LS) &&
                     (ctl_end > {1'b0, `MCAH_ADDR_CTL});
  assign ctl_exact = (i_req_addr == `MCAH_ADDR_CTL) &&
                     (i_req_qty == `MCAH_CTL_QTY) &&
                     (i_req_bytes == `MCAH_CTL_BYTES);
  assign qty_bytes = {i_req_qty[7:0], 1'b0};
  assign pt_ok     = (i_req_addr == `MCAH_ADDR_PT_CMD) &&
                     (i_req_qty != 16'h0000) &&
                     (i_req_qty <= `MCAH_MAX_RD_QTY) &&
                     ({1'b0, i_req_bytes} == qty_bytes);
  assign rd_ok     = (i_req_addr == `MCAH_ADDR_PT_RPL) &&
                     (i_req_qty != 16'h0000) &&
                     (i_req_qty <= `MCAH_MAX_RD_QTY);

  // Action bytes in the order they arrive
  assign b1 = ctl_sh[`MCAH_SL_B1];
  assign b0 = ctl_sh[`MCAH_SL_B0];
  assign b2 = ctl_sh[`MCAH_SL_B2];
  // Optional complement check on the spare bytes
  assign cpl_ok = (P_CHECK_CPL == 0) ||
                  ((ctl_sh[`MCAH_SL_C2] == ~b2) &&
                   (ctl_sh[`MCAH_SL_C0] == ~b0) &&
                   (ctl_sh[`MCAH_SL_C1] == ~b1));

  // Words beyond the held messages read as zero
  assign in_range = {1'b0, cnt[7:2]} < {{(6-P_MSG_AW){1'b0}},
                                         o_reply_message_count};

  mcah_reply_store #(
    .P_AW (P_MSG_AW),
    .P_DW (32)
  ) u_store (
    .i_clk     (i_clk),
    .i_wr_en   (i_fb_rsp_valid && (o_reply_message_count < DEPTH)),
    .i_wr_addr (o_reply_message_count[P_MSG_AW-1:0]),
    .i_wr_data ({i_fb_rsp_ok ? `MCAH_STAT_OK : `MCAH_STAT_BAD,
                 i_fb_rsp_data}),
    .i_rd_addr (cnt[P_MSG_AW+1:2]),
    .o_rd_data (rd_word)
  );

  // Held reply count; a new command empties the store
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reply_message_count <= {(P_MSG_AW+1){1'b0}};
    end else if (state == S_IDLE && i_req_valid && o_req_ready &&
                 i_req_func == `MCAH_FN_WRITE && pt_ok) begin
      o_reply_message_count <= {(P_MSG_AW+1){1'b0}};
    end else if (i_fb_rsp_valid && o_reply_message_count < DEPTH) begin
      o_reply_message_count <= o_reply_message_count + 1'b1;
    end
  end

  // Main sequencer
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state          <= S_IDLE;
      func           <= 8'h00;
      addr           <= 16'h0000;
      qty            <= 16'h0000;
      nbytes         <= 8'h00;
      cnt            <= 8'h00;
      ctl_sh         <= 48'h000000000000;
      rd_req         <= 1'b0;
      o_req_ready    <= 1'b0;
      o_wr_ready     <= 1'b0;
      o_rsp_valid    <= 1'b0;
      o_rsp_func     <= 8'h00;
      o_rsp_addr     <= 16'h0000;
      o_rsp_qty      <= 16'h0000;
      o_rsp_bytes    <= 8'h00;
      o_rsp_exc_code <= `MCAH_EXC_NONE;
      o_rd_valid     <= 1'b0;
      o_rd_byte      <= 8'h00;
      o_rd_last      <= 1'b0;
      o_action       <= {`MCAH_ACT_W{1'b0}};
      o_relay        <= 2'b00;
      o_fb_cmd_valid <= 1'b0;
      o_fb_cmd_byte  <= 8'h00;
      o_fb_cmd_last  <= 1'b0;
    end else begin
      // Pulses last one cycle
      o_rsp_valid <= 1'b0;
      o_rd_valid  <= 1'b0;
      o_rd_last   <= 1'b0;
      o_action    <= {`MCAH_ACT_W{1'b0}};
      case (state)
        S_IDLE: begin
          o_req_ready <= 1'b1;
          if (i_req_valid && o_req_ready) begin
            o_req_ready    <= 1'b0;
            func           <= i_req_func;
            addr           <= i_req_addr;
            qty            <= i_req_qty;
            nbytes         <= i_req_bytes;
            cnt            <= 8'h00;
            rd_req         <= 1'b0;
            o_rsp_exc_code <= `MCAH_EXC_NONE;
            // Requests that carry bytes but are refused still drain them
            state          <= (i_req_bytes == 8'h00) ? S_RSP : S_DRAIN;
            o_wr_ready     <= (i_req_bytes != 8'h00);
            if (i_req_func == `MCAH_FN_WRITE) begin
              if (ctl_touch && ctl_exact) begin
                state <= S_CTL;
              end else if (ctl_touch) begin
                o_rsp_exc_code <= `MCAH_EXC_ADDR;
              end else if (pt_ok) begin
                state <= S_PT;
              end else begin
                o_rsp_exc_code <= `MCAH_EXC_ADDR;
              end
            end else if (i_req_func == `MCAH_FN_READ) begin
              if (rd_ok) begin
                rd_req <= 1'b1;
              end else if (i_req_addr == `MCAH_ADDR_PT_RPL) begin
                o_rsp_exc_code <= `MCAH_EXC_DATA;
              end else begin
                o_rsp_exc_code <= `MCAH_EXC_ADDR;
              end
            end else begin
              o_rsp_exc_code <= `MCAH_EXC_FUNC;
            end
          end
        end
        S_CTL: begin
          if (i_wr_valid && o_wr_ready) begin
            ctl_sh <= {ctl_sh[39:0], i_wr_byte};
            cnt    <= cnt + 1'b1;
            if (cnt == nbytes - 1'b1) begin
              o_wr_ready <= 1'b0;
              state      <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          // Lock blocks every action but the reply is still normal
          if (cpl_ok && !i_system_lock_state) begin
            o_action <= mcah_decode(b2, b1, b0);
            if (b2 == `MCAH_G_RELAY &&
                (b0 == `MCAH_B_ONE || b0 == `MCAH_B_TWO)) begin
              if (b1 == `MCAH_B_ONE) begin
                o_relay[b0[1]] <= 1'b1;
              end else if (b1 == `MCAH_B_TWO) begin
                o_relay[b0[1]] <= 1'b0;
              end
            end
          end
          state <= S_RSP;
        end
        S_PT: begin
          // One byte in flight; ready drops until the product takes it
          if (o_fb_cmd_valid && i_fb_cmd_ready) begin
            o_fb_cmd_valid <= 1'b0;
            o_fb_cmd_last  <= 1'b0;
            if (o_fb_cmd_last) begin
              state <= S_RSP;
            end else begin
              o_wr_ready <= 1'b1;
            end
          end else if (i_wr_valid && o_wr_ready) begin
            o_fb_cmd_valid <= 1'b1;
            o_fb_cmd_byte  <= i_wr_byte;
            o_fb_cmd_last  <= (cnt == nbytes - 1'b1);
            o_wr_ready     <= 1'b0;
            cnt            <= cnt + 1'b1;
          end
        end
        S_DRAIN: begin
          if (i_wr_valid && o_wr_ready) begin
            cnt <= cnt + 1'b1;
            if (cnt == nbytes - 1'b1) begin
              o_wr_ready <= 1'b0;
              state      <= S_RSP;
            end
          end
        end
        S_RSP: begin
          o_rsp_valid <= 1'b1;
          o_rsp_addr  <= addr;
          o_rsp_qty   <= qty;
          o_rsp_bytes <= 8'h00;
          cnt         <= 8'h00;
          if (o_rsp_exc_code != `MCAH_EXC_NONE) begin
            o_rsp_func <= func | `MCAH_FN_EXC_BIT;
            state      <= S_IDLE;
          end else if (rd_req) begin
            o_rsp_func  <= func;
            o_rsp_bytes <= {qty[6:0], 1'b0};
            state       <= S_RD;
          end else begin
            o_rsp_func <= func;
            state      <= S_IDLE;
          end
        end
        S_RD: begin
          o_rd_valid <= 1'b1;
          o_rd_byte  <= in_range ? mcah_lane(rd_word, cnt[1:0])
                                 : 8'h00;
          cnt        <= cnt + 1'b1;
          if (cnt == {qty[6:0], 1'b0} - 1'b1) begin
            o_rd_last <= 1'b1;
            state     <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [mcah_handler_sva.sv]
// Purpose: Port-level checks of the control action handler.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes:   Bound into every handler instance; watches outputs, i_system_lock_state and i_fb_cmd_ready.
`timescale 1ns/10ps
`include "mcah_consts.vh"
module mcah_handler_sva (
  // Clock and reset
  input wire                    i_clk,
  input wire                    i_rst,
  // Response header and read data
  input wire                    o_rsp_valid,
  input wire [7:0]              o_rsp_func,
  input wire [15:0]             o_rsp_addr,
  input wire [15:0]             o_rsp_qty,
  input wire [7:0]              o_rsp_bytes,
  input wire [7:0]              o_rsp_exc_code,
  input wire                    o_rd_valid,
  // Lock, actions and forwarding
  input wire                    i_system_lock_state,
  input wire [`MCAH_ACT_W-1:0]  o_action,
  input wire                    o_fb_cmd_valid,
  input wire [7:0]              o_fb_cmd_byte,
  input wire                    o_fb_cmd_last,
  input wire                    i_fb_cmd_ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Action and header steps of control and read transfers
  sequence s_act;
    o_action != 0;
  endsequence
  sequence s_ctl_hdr;
    o_rsp_valid && o_rsp_func == 8'h10 && o_rsp_addr == 16'h6200 &&
    o_rsp_qty == 16'h0003 && o_rsp_exc_code == 8'h00;
  endsequence
  sequence s_rd_hdr;
    o_rsp_valid && o_rsp_func == 8'h04 && o_rsp_exc_code == 8'h00;
  endsequence
  property p_onehot;
    $onehot0(o_action);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one action line at once");
  // Lock held across the decision cycles blocks every action
  property p_lock;
    i_system_lock_state && $past(i_system_lock_state) &&
    $past(i_system_lock_state, 2) |-> o_action == 0;
  endproperty
  a_lock: assert property (p_lock)
    else $error("action while system_lock_state");
  property p_act_hdr;
    s_act |=> s_ctl_hdr;
  endproperty
  a_act_hdr: assert property (p_act_hdr)
    else $error("action not followed by control echo header");
  property p_refused;
    o_rsp_valid && o_rsp_exc_code != 8'h00 |-> $past(o_action) == 0;
  endproperty
  a_refused: assert property (p_refused)
    else $error("refused request still fired an action");
  property p_func;
    o_rsp_valid |-> (o_rsp_exc_code == 8'h00 &&
      (o_rsp_func == 8'h04 || o_rsp_func == 8'h10)) ||
      (o_rsp_exc_code != 8'h00 && o_rsp_func[7]);
  endproperty
  a_func: assert property (p_func)
    else $error("served function outside 04 and 10h");
  property p_rd_count;
    s_rd_hdr |-> o_rsp_bytes == {o_rsp_qty[6:0], 1'b0};
  endproperty
  a_rd_count: assert property (p_rd_count)
    else $error("read byte count is not two per register");
  property p_rd_follow;
    s_rd_hdr |=> o_rd_valid;
  endproperty
  a_rd_follow: assert property (p_rd_follow)
    else $error("read header without data");
  property p_rsp_pulse;
    o_rsp_valid |=> !o_rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("response header longer than one cycle");
  // A forwarded byte may not move until the product takes it
  property p_fb_hold;
    o_fb_cmd_valid && !i_fb_cmd_ready |=> o_fb_cmd_valid &&
      $stable(o_fb_cmd_byte) && $stable(o_fb_cmd_last);
  endproperty
  a_fb_hold: assert property (p_fb_hold)
    else $error("forwarded byte changed before it was taken");
endmodule
bind mcah_handler mcah_handler_sva chk_u (.i_clk, .i_rst, .o_rsp_valid,
  .o_rsp_func, .o_rsp_addr, .o_rsp_qty, .o_rsp_bytes, .o_rsp_exc_code,
  .o_rd_valid, .i_system_lock_state, .o_action, .o_fb_cmd_valid,
  .o_fb_cmd_byte, .o_fb_cmd_last, .i_fb_cmd_ready);

// [mcah_fb_model.sv]
// Purpose: Field-bus product model on the handler's forwarding port.
// Assumes: A byte is taken on an edge with valid and ready both high.
// Notes:   Odd bytes wait three cycles; replies follow the last byte.
`timescale 1ns/10ps
module mcah_fb_model #(
  parameter [7:0] P_NMSG = 8'h03
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst,
  // Command side
  input  wire        i_cmd_valid,
  input  wire [7:0]  i_cmd_byte,
  input  wire        i_cmd_last,
  output reg         o_cmd_ready,
  // Reply side
  output reg         o_rsp_valid,
  output reg  [23:0] o_rsp_data,
  output reg         o_rsp_ok,
  // Bench view of the received command
  output reg  [31:0] o_seen,
  output reg  [7:0]  o_seen_n
);
  reg [7:0] left;
  reg [1:0] wait_c;
  // Take bytes, then send P_NMSG messages; message 2 is marked invalid
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cmd_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= 24'h5A5A5A;
      o_rsp_ok    <= 1'b0;
      o_seen      <= 32'h0;
      o_seen_n    <= 8'h00;
      left        <= 8'h00;
      wait_c      <= 2'h0;
    end else begin
      o_cmd_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= ~o_rsp_data;  // Data inverts every idle cycle, so the last message reappears on alternate cycles
      if (i_cmd_valid && o_cmd_ready) begin
        o_seen   <= {o_seen[23:0], i_cmd_byte};
        o_seen_n <= o_seen_n + 8'h01;
        if (i_cmd_last)
          left <= P_NMSG;
      end else if (i_cmd_valid) begin
        wait_c <= wait_c + 2'h1;
        if (wait_c == {o_seen_n[0], o_seen_n[0]}) begin
          o_cmd_ready <= 1'b1;
          wait_c      <= 2'h0;
        end
      end else if (left != 8'h00) begin
        o_rsp_valid <= 1'b1;
        o_rsp_data  <= {left, 8'hA5, 8'h3C ^ left};
        o_rsp_ok    <= left != 8'h02;
        left        <= left - 8'h01;
      end
    end
  end
endmodule

// [mcah_handler_tb.sv]
// Purpose: Self-checking bench of the control action handler.
// Assumes: Product model answers a forwarded command with three messages.
// Notes:   One request at a time; inputs move 1 ns after the rising edge.
`timescale 1ns/10ps
`include "mcah_consts.vh"
module mcah_handler_tb;
  // Stimulus
  reg                    i_clk = 1'b0;
  reg                    i_rst = 1'b1;
  reg                    i_req_valid = 1'b0;
  reg  [7:0]             i_req_func = 8'h00;
  reg  [15:0]            i_req_addr = 16'h0000;
  reg  [15:0]            i_req_qty = 16'h0000;
  reg  [7:0]             i_req_bytes = 8'h00;
  reg                    i_wr_valid = 1'b0;
  reg  [7:0]             i_wr_byte = 8'h00;
  reg                    i_system_lock_state = 1'b0;
  // Design and model outputs
  wire                   o_req_ready, o_wr_ready, o_rsp_valid, o_rd_valid;
  wire                   o_rd_last, o_fb_cmd_valid, o_fb_cmd_last;
  wire                   i_fb_cmd_ready, i_fb_rsp_valid, i_fb_rsp_ok;
  wire [7:0]             o_rsp_func, o_rsp_bytes, o_rsp_exc_code, o_rd_byte;
  wire [7:0]             o_fb_cmd_byte, seen_n;
  wire [15:0]            o_rsp_addr, o_rsp_qty;
  wire [23:0]            i_fb_rsp_data;
  wire [31:0]            seen;
  wire [`MCAH_ACT_W-1:0] o_action;
  wire [1:0]             o_relay;
  wire [4:0]             o_reply_message_count;
  // Bench state
  integer                errors = 0;
  integer                checks_done = 0;
  integer                nrsp = 0;
  integer                nrd = 0;
  integer                i, k, nlast;
  reg  [7:0]             wb [0:7];
  reg  [7:0]             rb [0:15];
  reg  [`MCAH_ACT_W-1:0] act_acc = 0;

  mcah_handler dut_u (.i_clk, .i_rst, .i_req_valid, .i_req_func,
    .i_req_addr, .i_req_qty, .i_req_bytes, .o_req_ready, .i_wr_valid,
    .i_wr_byte, .o_wr_ready, .o_rsp_valid, .o_rsp_func, .o_rsp_addr,
    .o_rsp_qty, .o_rsp_bytes, .o_rsp_exc_code, .o_rd_valid, .o_rd_byte,
    .o_rd_last, .i_system_lock_state, .o_action, .o_relay, .o_fb_cmd_valid,
    .o_fb_cmd_byte, .o_fb_cmd_last, .i_fb_cmd_ready, .i_fb_rsp_valid,
    .i_fb_rsp_data, .i_fb_rsp_ok, .o_reply_message_count);
  mcah_fb_model fb_u (.i_clk(i_clk), .i_rst(i_rst),
    .i_cmd_valid(o_fb_cmd_valid), .i_cmd_byte(o_fb_cmd_byte),
    .i_cmd_last(o_fb_cmd_last), .o_cmd_ready(i_fb_cmd_ready),
    .o_rsp_valid(i_fb_rsp_valid), .o_rsp_data(i_fb_rsp_data),
    .o_rsp_ok(i_fb_rsp_ok), .o_seen(seen), .o_seen_n(seen_n));

  always #25 i_clk = ~i_clk;
  // Collect headers, read bytes and action pulses as they stand
  always @(posedge i_clk) begin
    if (o_rsp_valid)
      nrsp <= nrsp + 1;
    if (i_req_valid && o_req_ready)
      nrd <= 0;
    if (o_rd_valid) begin
      rb[nrd[3:0]] <= o_rd_byte;
      nrd <= nrd + 1;
      if (o_rd_last) nlast <= nrd + 1;
    end
    act_acc <= (i_req_valid && o_req_ready) ? '0 : act_acc | o_action;
  end

  task chk(input string nm, input [47:0] seen_v, input [47:0] exp_v);
    begin
      checks_done = checks_done + 1;
      if (seen_v !== exp_v) begin
        errors = errors + 1;
        $display("BAD %0s exp %0h seen %0h", nm, exp_v, seen_v);
      end
    end
  endtask

  // One request: header, data bytes, then wait for header and idle
  task xfer(input [7:0] f, input [15:0] a, input [15:0] q, input [7:0] nb);
    integer j, n;
    begin
      n = nrsp;
      i_req_valid = 1'b1;
      i_req_func = f;
      i_req_addr = a;
      i_req_qty = q;
      i_req_bytes = nb;
      @(posedge i_clk);
      while (!o_req_ready) @(posedge i_clk);
      #1 i_req_valid = 1'b0;
      for (j = 0; j < nb; j = j + 1) begin
        i_wr_valid = 1'b1;
        i_wr_byte = wb[j];
        @(posedge i_clk);
        while (!o_wr_ready) @(posedge i_clk);
        #1;
      end
      i_wr_valid = 1'b0;
      j = 0;
      while (nrsp == n && j < 300) begin
        @(posedge i_clk);
        j = j + 1;
      end
      chk("header_count", nrsp - n, 1);
      while (!o_req_ready) @(posedge i_clk);
      #1;
    end
  endtask

  task ctl(input [7:0] b2, input [7:0] b1, input [7:0] b0);
    begin
      wb[0] = b1;
      wb[1] = b0;
      wb[2] = ~b2;
      wb[3] = b2;
      wb[4] = ~b0;
      wb[5] = ~b1;
      xfer(8'h10, 16'h6200, 16'h0003, 8'h06);
    end
  endtask

  function [23:0] code_of(input integer n);
    case (n)
      0: code_of = 24'h000004;
      1: code_of = 24'h000008;
      2: code_of = 24'h000040;
      3: code_of = 24'h000080;
      4: code_of = 24'h000101;
      5: code_of = 24'h000104;
      6: code_of = 24'h000106;
      13: code_of = 24'h030002;
      14: code_of = 24'h030003;
      15: code_of = 24'h030006;
      16: code_of = 24'h060600;
      default: code_of = 24'h000106 + n; // Min/max groups 13..18
    endcase
  endfunction

  // Message m of the model carries count 3-m; message 1 is invalid
  task rdchk(input integer n);
    integer j;
    reg [7:0] l, e;
    begin
      chk("rd_count", nrd, n);
      chk("rd_last", nlast, n);
      for (j = 0; j < n; j = j + 1) begin
        l = 8'h03 - j / 4;
        case (j % 4)
          0: e = (l == 8'h02) ? 8'hFF : 8'h00;
          1: e = l;
          2: e = 8'hA5;
          default: e = 8'h3C ^ l;
        endcase
        chk("rd_byte", rb[j], e);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_rst = 1'b0;
    // Every recognised code fires its own action line and a clean echo
    for (i = 0; i < 17; i = i + 1) begin
      ctl(code_of(i) >> 16, code_of(i) >> 8, code_of(i));
      chk("action", act_acc, 1 << i);
      chk("ctl_hdr", {o_rsp_func, o_rsp_exc_code, o_rsp_addr, o_rsp_qty},
          48'h1000_6200_0003);
    end
    // Both relays set one by one, then relay 1 clears; a bad relay number does nothing
    ctl(8'h04, 8'h01, 8'h01);
    chk("relay", o_relay, 2'b01);
    ctl(8'h04, 8'h01, 8'h02);
    chk("relay", o_relay, 2'b11);
    ctl(8'h04, 8'h02, 8'h01);
    chk("relay", o_relay, 2'b10);
    ctl(8'h04, 8'h01, 8'h03);
    chk("relay", o_relay, 2'b10);
    // Lock, unknown codes and malformed writes fire nothing
    i_system_lock_state = 1'b1;
    ctl(8'h00, 8'h01, 8'h04);
    chk("system_lock_state", act_acc, 0);
    i_system_lock_state = 1'b0;
    ctl(8'h00, 8'h00, 8'h05);
    chk("unknown", act_acc, 0);
    xfer(8'h10, 16'h6201, 16'h0002, 8'h04);
    chk("partial", {act_acc, o_rsp_func, o_rsp_exc_code}, 16'h9002);
    xfer(8'h10, 16'h6200, 16'h0004, 8'h08);
    chk("extended", {act_acc, o_rsp_func, o_rsp_exc_code}, 16'h9002);
    xfer(8'h03, 16'h6100, 16'h0002, 8'h00);
    chk("bad_func", {o_rsp_func, o_rsp_exc_code}, 16'h8301);
    // Pass-through command, slow product, then read back twice
    wb[0] = 8'h03;
    wb[1] = 8'h84;
    wb[2] = 8'h50;
    wb[3] = 8'h00;
    xfer(8'h10, 16'h6000, 16'h0002, 8'h04);
    chk("pt_hdr", {o_rsp_func, o_rsp_exc_code, o_rsp_addr, o_rsp_qty},
        48'h1000_6000_0002);
    chk("forwarded", {seen_n, seen}, 40'h04_0384_5000);
    k = 0;
    while (o_reply_message_count !== 5'h03 && k < 100) begin
      @(posedge i_clk);
      k = k + 1;
    end
    #1;
    chk("held", o_reply_message_count, 3);
    xfer(8'h04, 16'h6100, 16'h0006, 8'h00);
    chk("rd_hdr", {o_rsp_func, o_rsp_exc_code, o_rsp_bytes}, 24'h04000C);
    rdchk(12);
    xfer(8'h04, 16'h6100, 16'h0002, 8'h00);
    rdchk(4);
    xfer(8'h04, 16'h6200, 16'h0002, 8'h00);
    chk("rd_addr", {o_rsp_func, o_rsp_exc_code}, 16'h8402);
    xfer(8'h04, 16'h6100, 16'h0000, 8'h00);
    chk("rd_qty", {o_rsp_func, o_rsp_exc_code}, 16'h8403);
    print_verdict;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(50 * 20000);
    errors = errors + 1;
    print_verdict;
  end
endmodule
